// ===== src/phrb_regbank.sv
// Purpose: Host register bank of a DIMM power manager on APB.
// Assumes: rst_b is a power cycle; pers_rst_b clears persistent state.
// Notes:   Access phase takes two cycles; pready rises on the second.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module phrb_regbank
  import phrb_pkg::*;
#(
  parameter logic [15:0] PASSWORD = 16'h5a3c
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        pers_rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vin_ov_raw,
  input  wire logic        crit_temp_raw,
  input  wire logic        hi_temp_raw,
  input  wire logic [2:0]  rail_pg_raw,
  input  wire logic        ldo18_pg_raw,
  input  wire logic [2:0]  rail_hicur_raw,
  input  wire logic [2:0]  rail_ov_raw,
  input  wire logic [2:0]  rail_ilim_raw,
  input  wire logic [2:0]  rail_uvlo_raw,
  input  wire logic        pec_err,
  input  wire logic        parity_err,
  input  wire logic        ibi_event,
  input  wire logic [7:0]  meas_a,
  input  wire logic [5:0]  meas_b,
  input  wire logic [5:0]  meas_c,
  input  wire logic [2:0]  por_err_code,
  output logic             status_alert_n,
  output logic             power_ok_out,
  output logic             secure_mode
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    phrb_fsm_t       fsm;
    logic [3:0]      cnt;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [3:0][7:0] stat;
    logic [7:0]      pw0;
    logic [7:0]      pw1;
    logic            secure;
    logic            alert_n;
    logic            pok;
  } phrb_state_t;

  typedef struct packed {
    logic [7:0] elog;
    logic [7:0] porlog;
    logic [7:0] poflog;
  } phrb_pers_t;

  phrb_state_t st, nx;
  phrb_pers_t  pl, pl_nx;

  function automatic logic in_rng(input logic [7:0] a,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // ---------------------------------------------------------------
  // Monitor inputs
  // ---------------------------------------------------------------
  logic [18:0] mon;
  logic        s_vin_ov, s_crit, s_hi_temp, s_ldo18;
  logic [2:0]  s_pg, s_hicur, s_ov, s_ilim, s_uvlo;

  phrb_sync #(.W(19)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({vin_ov_raw, crit_temp_raw, hi_temp_raw, rail_pg_raw,
             ldo18_pg_raw, rail_hicur_raw, rail_ov_raw, rail_ilim_raw,
             rail_uvlo_raw}),
    .q     (mon)
  );

  assign {s_vin_ov, s_crit, s_hi_temp, s_pg, s_ldo18,
          s_hicur, s_ov, s_ilim, s_uvlo} = mon;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [7:0] idx;
  logic       addr_ok, rd_phase, wr_done, rd_done, unlocked, in_vend, in_host;

  assign idx      = paddr[9:2];
  assign addr_ok  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && (idx <= IDX_VEND_HI);
  assign rd_phase = psel && penable && !st.pready && (st.fsm == FSM_RUN);
  assign wr_done  = psel && penable && st.pready && pwrite && addr_ok;
  assign rd_done  = psel && penable && st.pready && !pwrite;
  assign unlocked = ({st.pw1, st.pw0} == PASSWORD);
  assign in_vend  = in_rng(idx, IDX_VEND_LO, IDX_VEND_HI);
  assign in_host  = in_rng(idx, IDX_HOST_LO, IDX_HOST_HI);

  // ---------------------------------------------------------------
  // Memories
  // ---------------------------------------------------------------
  logic       n_we, h_we, copying;
  logic [5:0] n_addr;
  logic [3:0] h_addr;
  logic [7:0] n_rd, h_wd, h_rd;

  assign copying = (st.fsm == FSM_COPY);
  assign n_addr  = copying ? 6'(COPY_SRC + 6'(st.cnt)) : idx[5:0];
  assign h_addr  = copying ? 4'(st.cnt - 4'h1) : idx[3:0];
  assign h_wd    = copying ? n_rd : pwdata[7:0];
  assign h_we    = (copying && (st.cnt != 4'h0)) || (wr_done && in_host && !st.secure);
  assign n_we    = wr_done && in_vend && unlocked && !st.secure;

  phrb_mem #(.AW(6), .DEPTH(64)) u_vendor (
    .clk   (clk),
    .rst_b (pers_rst_b),
    .we    (n_we),
    .addr  (n_addr),
    .wdata (pwdata[7:0]),
    .rdata (n_rd)
  );

  phrb_mem #(.AW(4), .DEPTH(16)) u_host (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (h_we),
    .addr  (h_addr),
    .wdata (h_wd),
    .rdata (h_rd)
  );

  // ---------------------------------------------------------------
  // Status sources
  // ---------------------------------------------------------------
  logic [3:0][7:0] src;
  logic            gclr;

  always_comb begin
    src[0] = {1'b0, s_crit, ~s_pg[0], 1'b0, ~s_pg[1], ~s_pg[2], 1'b0, s_vin_ov};
    src[1] = {s_hi_temp, 1'b0, ~s_ldo18, 1'b0, s_hicur[0], 1'b0, s_hicur[1], s_hicur[2]};
    src[2] = {s_ov[0], 1'b0, s_ov[1], s_ov[2], pec_err, parity_err, ibi_event, 1'b0};
    src[3] = {s_ilim[0], 1'b0, s_ilim[1], s_ilim[2], s_uvlo[0], 1'b0, s_uvlo[1], s_uvlo[2]};
  end

  assign gclr = wr_done && (idx == IDX_GCLR) && pwdata[GCLR_BIT];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nx         = st;
    nx.pready  = 1'b0;
    nx.pslverr = 1'b0;
    unique case (st.fsm)
      FSM_COPY: begin
        nx.cnt = 4'(st.cnt + 4'h1);
        if (st.cnt == COPY_N) begin
          nx.fsm = FSM_SETTLE;
        end
      end
      FSM_SETTLE: begin
        nx.fsm = FSM_RUN;
      end
      FSM_RUN: begin
        nx.fsm = FSM_RUN;
      end
    endcase
    nx.stat    = (gclr ? '0 : st.stat) | src;
    nx.alert_n = ~|nx.stat;
    nx.pok     = ~|{nx.stat[0] & PF_MASK_PG, nx.stat[1] & PF_MASK_WRN,
                    nx.stat[2] & PF_MASK_OV, nx.stat[3] & PF_MASK_LIM};
    if (wr_done && (idx == IDX_PW0)) begin
      nx.pw0 = pwdata[7:0];
    end
    if (wr_done && (idx == IDX_PW1)) begin
      nx.pw1 = pwdata[7:0];
    end
    if (wr_done && (idx == IDX_MODE) && !st.secure) begin
      nx.secure = pwdata[SECURE_BIT];
    end
    if (rd_phase) begin
      nx.pready  = 1'b1;
      nx.pslverr = !addr_ok;
      nx.prdata  = WORD_RST;
      if (addr_ok && !pwrite) begin
        unique case (idx)
          IDX_ERR_LOG:   nx.prdata[7:0] = pl.elog;
          IDX_POR_LOG:   nx.prdata[7:0] = pl.porlog;
          IDX_POF_LOG:   nx.prdata[7:0] = pl.poflog;
          IDX_STAT_PG:   nx.prdata[7:0] = st.stat[0];
          IDX_STAT_WARN: nx.prdata[7:0] = st.stat[1];
          IDX_STAT_OV:   nx.prdata[7:0] = st.stat[2];
          IDX_STAT_LIM:  nx.prdata[7:0] = st.stat[3];
          IDX_MEAS_A:    nx.prdata[7:0] = meas_a;
          IDX_MEAS_B:    nx.prdata[5:0] = meas_b;
          IDX_MEAS_C:    nx.prdata[5:0] = meas_c;
          default: begin
            if (in_host) begin
              nx.prdata[7:0] = h_rd;
            end else if (in_vend && unlocked) begin
              nx.prdata[7:0] = n_rd;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Persistent logs
  // ---------------------------------------------------------------
  logic buck_flt;

  assign buck_flt = |{s_ov, s_uvlo};

  always_comb begin
    pl_nx      = pl;
    pl_nx.elog = pl.elog | {buck_flt | s_vin_ov | s_crit, buck_flt, s_vin_ov, s_crit, 4'h0};
    pl_nx.poflog = pl.poflog | {s_uvlo[0], 1'b0, s_uvlo[1], s_uvlo[2], s_ov[0], 1'b0, s_ov[1], s_ov[2]};
    if (copying && (st.cnt == COPY_N)) begin
      pl_nx.porlog = {1'b0, ~s_pg[0], 1'b0, ~s_pg[1], ~s_pg[2], por_err_code};
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st         <= '0;
      st.fsm     <= FSM_COPY;
      st.secure  <= SECURE_RST;
      st.alert_n <= 1'b1;
      st.pok     <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // Logs ride a separate reset so a power cycle does not clear them; the POR log is reloaded at the end of the copy.
  always_ff @(posedge clk or negedge pers_rst_b) begin
    if (!pers_rst_b) begin
      pl <= {BYTE_RST, BYTE_RST, BYTE_RST};
    end else begin
      pl <= pl_nx;
    end
  end

  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign status_alert_n = st.alert_n;
  assign power_ok_out   = st.pok;
  assign secure_mode    = st.secure;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_gclr_one;
    wr_done && (idx == IDX_GCLR) && pwdata[GCLR_BIT];
  endsequence

  sequence s_gclr_zero;
    wr_done && (idx == IDX_GCLR) && !pwdata[GCLR_BIT];
  endsequence

  property p_wo_zero;
    rd_done && ((idx == IDX_PW0) || (idx == IDX_PW1)) |-> prdata == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("Write-only register read back nonzero.");
  property p_rsvd_zero;
    rd_done && (idx < IDX_ERR_LOG) |-> prdata == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved register read back nonzero.");
  property p_w0_noclr;
    s_gclr_zero |=> ((st.stat & $past(st.stat)) == $past(st.stat));
  endproperty
  a_w0_noclr: assert property (p_w0_noclr) else $error("Writing zero to the clear bit dropped status.");
  property p_lock_zero;
    rd_done && in_vend && !unlocked |-> prdata == 32'h0;
  endproperty
  a_lock_zero: assert property (p_lock_zero) else $error("Locked vendor read returned data.");
  property p_secure_block;
    st.secure && wr_done && (in_host || in_vend) |-> !h_we && !n_we;
  endproperty
  a_secure_block: assert property (p_secure_block) else $error("Write landed while in secure mode.");
  property p_copy_bound;
    (st.fsm == FSM_COPY) |-> ##[0:16] (st.fsm == FSM_RUN);
  endproperty
  a_copy_bound: assert property (p_copy_bound) else $error("Power-on copy did not finish in time.");
  property p_crit_log;
    s_crit |=> pl.elog[4] && pl.elog[7];
  endproperty
  a_crit_log: assert property (p_crit_log) else $error("Critical temperature was not logged.");
  property p_meas_a;
    rd_done && (idx == IDX_MEAS_A) |-> prdata[7:0] == $past(meas_a);
  endproperty
  a_meas_a: assert property (p_meas_a) else $error("Rail A measurement read wrong.");
  property p_clear_all;
    s_gclr_one ##0 (src == '0) |=> (st.stat == '0) ##1 status_alert_n;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("Global clear left status set.");
  property p_set_wins;
    s_gclr_one ##0 s_vin_ov |=> st.stat[0][0] && !status_alert_n;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Event lost against global clear.");

endmodule // phrb_regbank

// ===== src/phrb_pkg.sv
// Purpose: Shared constants and types of the host register bank.
// Assumes: Registers sit on APB, one 32-bit word per 8-bit index.
// Notes:   Byte address of a register is four times its index.
package phrb_pkg;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ERR_LOG   = 8'h04;
  localparam logic [7:0] IDX_POR_LOG   = 8'h05;
  localparam logic [7:0] IDX_POF_LOG   = 8'h06;
  localparam logic [7:0] IDX_STAT_PG   = 8'h08;
  localparam logic [7:0] IDX_STAT_WARN = 8'h09;
  localparam logic [7:0] IDX_STAT_OV   = 8'h0a;
  localparam logic [7:0] IDX_STAT_LIM  = 8'h0b;
  localparam logic [7:0] IDX_MEAS_A    = 8'h0c;
  localparam logic [7:0] IDX_MEAS_B    = 8'h0e;
  localparam logic [7:0] IDX_MEAS_C    = 8'h0f;
  localparam logic [7:0] IDX_GCLR      = 8'h14;
  localparam logic [7:0] IDX_HOST_LO   = 8'h20;
  localparam logic [7:0] IDX_HOST_HI   = 8'h2f;
  localparam logic [7:0] IDX_MODE      = 8'h2f;
  localparam logic [7:0] IDX_PW0       = 8'h37;
  localparam logic [7:0] IDX_PW1       = 8'h38;
  localparam logic [7:0] IDX_VEND_LO   = 8'h40;
  localparam logic [7:0] IDX_VEND_HI   = 8'h6f;

  // ---------------------------------------------------------------
  // Field positions and copy window
  // ---------------------------------------------------------------
  localparam int         GCLR_BIT   = 0;
  localparam int         SECURE_BIT = 2;
  localparam logic [3:0] COPY_N     = 4'he;
  localparam logic [5:0] COPY_SRC   = 6'h04;

  // Latched status bits that pull the power-ok output low.
  localparam logic [7:0] PF_MASK_PG  = 8'h6d;
  localparam logic [7:0] PF_MASK_WRN = 8'h20;
  localparam logic [7:0] PF_MASK_OV  = 8'hb0;
  localparam logic [7:0] PF_MASK_LIM = 8'h0b;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;
  localparam logic        SECURE_RST = 1'b0;

  typedef enum logic [2:0] {
    FSM_COPY   = 3'b001,
    FSM_SETTLE = 3'b010,
    FSM_RUN    = 3'b100
  } phrb_fsm_t;

endpackage

// ===== src/phrb_sync.sv
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Inputs are asynchronous monitor levels.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
module phrb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } phrb_sync_t;

  phrb_sync_t st;
  phrb_sync_t nx;

  always_comb begin
    nx    = st;
    nx.s1 = d;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.q  = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign q = st.q;

endmodule // phrb_sync

// ===== src/phrb_mem.sv
// Purpose: Small byte memory with registered read data.
// Assumes: One port; read and write share the address.
// Notes:   Cleared only by its own reset input.
`timescale 1ns/1ps
module phrb_mem #(
  parameter int AW    = 6,
  parameter int DEPTH = 64
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rd;
  } phrb_mem_t;

  phrb_mem_t st;
  phrb_mem_t nx;

  always_comb begin
    nx    = st;
    nx.rd = st.mem[addr];
    if (we) begin
      nx.mem[addr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign rdata = st.rd;

endmodule // phrb_mem

// ===== dv/phrb_host_model.sv
// Purpose: APB host model that issues single transfers to the bank.
// Assumes: The slave answers with a one-cycle pready pulse.
// Notes:   A wait that runs past its bound is reported as a timeout.
`timescale 1ns/1ps
module phrb_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  // ---------------------------------------------------------------
  // Transfer
  // ---------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // reserved and vendor writes only on purpose.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic to);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 300);
    rd  = prdata;
    err = pslverr;
    to  = (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // phrb_host_model

// ===== dv/pmic_host_register_bank_bench.sv
// Purpose: Self-checking bench of the host register bank.
// Assumes: Monitor levels come from one event vector, ev.
// Notes:   Power-good sync resets low, so each reset is followed by a clear.
`timescale 1ns/1ps
module pmic_host_register_bank_bench
  import phrb_pkg::*;
;
  // Password value is arbitrary.
  localparam logic [15:0] PW   = 16'h5a3c;
  localparam logic [7:0]  VIDX = 8'h44;
  localparam logic [7:0]  RSV [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h0d};
  // Each entry holds expected power-ok level, status index and latched bit.
  localparam logic [16:0] EVT [22] = '{17'h00801, 17'h00840, 17'h00820, 17'h00808,
    17'h00804, 17'h10980, 17'h00920, 17'h10908, 17'h10902, 17'h10901, 17'h00a80,
    17'h00a20, 17'h00a10, 17'h10a08, 17'h10a04, 17'h10a02, 17'h10b80, 17'h10b20,
    17'h10b10, 17'h00b08, 17'h00b02, 17'h00b01};
  logic        clk, rst_b, pers_rst_b, psel, penable, pwrite, pready, pslverr;
  logic        status_alert_n, power_ok_out, secure_mode, er, to;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [21:0] ev;
  logic [7:0]  meas_a;
  logic [5:0]  meas_b, meas_c;
  logic [2:0]  por_err_code;
  int          error_cnt, n_compared;

  phrb_regbank #(.PASSWORD(PW)) uut (.clk(clk), .rst_b(rst_b), .pers_rst_b(pers_rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .vin_ov_raw(ev[0]),
    .crit_temp_raw(ev[1]), .rail_pg_raw(~ev[4:2]), .hi_temp_raw(ev[5]),
    .ldo18_pg_raw(~ev[6]), .rail_hicur_raw(ev[9:7]), .rail_ov_raw(ev[12:10]),
    .pec_err(ev[13]), .parity_err(ev[14]), .ibi_event(ev[15]), .rail_ilim_raw(ev[18:16]),
    .rail_uvlo_raw(ev[21:19]), .meas_a(meas_a), .meas_b(meas_b), .meas_c(meas_c),
    .por_err_code(por_err_code), .status_alert_n(status_alert_n),
    .power_ok_out(power_ok_out), .secure_mode(secure_mode));

  phrb_host_model host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    host.xfer(w, a, {24'h0, d}, rv, er, to);
    if (to) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, {2'b00, idx, 2'b00}, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    acc(1'b0, {2'b00, idx, 2'b00}, 8'h00);
    chk(rv, {24'h0, e});
  endtask

  task automatic flags(input logic a, input logic p);
    repeat (3) @(posedge clk);
    chk({30'h0, status_alert_n, power_ok_out}, {30'h0, a, p});
  endtask

  task automatic pcyc();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    wr(IDX_GCLR, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    pers_rst_b = 1'b0;
    ev = '0;
    meas_a = 8'ha5;
    meas_b = 6'h2a;
    meas_c = 6'h15;
    por_err_code = 3'h5;
    error_cnt = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    pers_rst_b <= 1'b1;
    wr(IDX_GCLR, 8'h01);
    flags(1'b1, 1'b1);
    foreach (RSV[i]) begin
      wr(RSV[i], 8'hff);
      rdc(RSV[i], 8'h00);
      chk({31'h0, er}, 32'h0);
    end
    wr(IDX_MEAS_A, 8'hff);
    rdc(IDX_MEAS_A, 8'ha5);
    wr(IDX_STAT_PG, 8'hff);
    rdc(IDX_STAT_PG, 8'h00);
    rdc(IDX_MEAS_B, 8'h2a);
    rdc(IDX_MEAS_C, 8'h15);
    meas_a <= 8'h3c;
    rdc(IDX_MEAS_A, 8'h3c);
    rdc(IDX_POR_LOG, 8'h05);
    rdc(IDX_POF_LOG, 8'h00);
    foreach (EVT[i]) begin
      ev <= 22'(1) << i;
      repeat (6) @(posedge clk);
      ev <= '0;
      repeat (5) @(posedge clk);
      chk({30'h0, status_alert_n, power_ok_out}, {30'h0, 1'b0, EVT[i][16]});
      rdc(EVT[i][15:8], EVT[i][7:0]);
      wr(IDX_GCLR, 8'h01);
      rdc(EVT[i][15:8], 8'h00);
      flags(1'b1, 1'b1);
    end
    rdc(IDX_ERR_LOG, 8'hf0);
    rdc(IDX_POF_LOG, 8'hbb);
    ev <= 22'(1) << 13;
    repeat (2) @(posedge clk);
    ev <= '0;
    wr(IDX_GCLR, 8'h00);
    rdc(IDX_STAT_OV, 8'h08);
    wr(IDX_GCLR, 8'h01);
    // A clear that meets a standing event must leave the event latched.
    ev <= 22'h000001;
    repeat (6) @(posedge clk);
    wr(IDX_GCLR, 8'h01);
    rdc(IDX_STAT_PG, 8'h01);
    ev <= '0;
    repeat (5) @(posedge clk);
    wr(IDX_GCLR, 8'h01);
    rdc(IDX_STAT_PG, 8'h00);
    rdc(VIDX, 8'h00);
    wr(VIDX, 8'hc3);
    wr(IDX_PW0, PW[7:0]);
    wr(IDX_PW1, PW[15:8]);
    rdc(IDX_PW0, 8'h00);
    rdc(VIDX, 8'h00);
    wr(VIDX, 8'hc3);
    rdc(VIDX, 8'hc3);
    rdc(IDX_HOST_LO, 8'h00);
    pcyc();
    rdc(IDX_ERR_LOG, 8'hf0);
    rdc(IDX_POF_LOG, 8'hbb);
    rdc(IDX_HOST_LO, 8'hc3);
    rdc(VIDX, 8'h00);
    wr(8'h2e, 8'h05);
    wr(IDX_MODE, 8'h04);
    repeat (2) @(posedge clk);
    chk({31'h0, secure_mode}, 32'h1);
    wr(IDX_HOST_LO, 8'h00);
    wr(8'h2e, 8'h00);
    rdc(IDX_HOST_LO, 8'hc3);
    rdc(8'h2e, 8'h05);
    wr(IDX_PW0, PW[7:0]);
    wr(IDX_PW1, PW[15:8]);
    wr(VIDX, 8'h00);
    rdc(VIDX, 8'hc3);
    acc(1'b0, 12'h011, 8'h00);
    chk({31'h0, er}, 32'h1);
    acc(1'b0, 12'h1c0, 8'h00);
    chk({31'h0, er}, 32'h1);
    wrap_up();
  end
endmodule // pmic_host_register_bank_bench
